// File: rtcaic_pkg.sv
// rtcaic_pkg: constants of the alarm, interrupt and control block
// assumes a 250 MHz system clock and a 32.768 kHz timekeeping rate
`default_nettype none
package rtcaic_pkg;
    localparam int CLK_HZ        = 250_000_000;
    localparam int TICK_HZ       = 32768;
    // divider giving the crystal rate from the system clock, rounded down
    localparam int TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int SEC_TICKS     = 32768;
    localparam int HALF_MS       = 500;
    localparam int HALF_TICKS    = HALF_MS * TICK_HZ / 1000;
    localparam int BUC_US        = 244;
    localparam int BUC_TICKS     = (BUC_US * TICK_HZ + 999_999) / 1_000_000;
    localparam int GAP_MIN_MS    = 999;
    localparam int GAP_MIN_TICKS = (GAP_MIN_MS * TICK_HZ + 999) / 1000;
    localparam int CSR_CYCLES    = 250_000;
    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_SEC_ALM = 6'h01;
    localparam logic [5:0] IDX_MIN_ALM = 6'h03;
    localparam logic [5:0] IDX_HR_ALM  = 6'h05;
    localparam logic [5:0] IDX_RATE    = 6'h0a;
    localparam logic [5:0] IDX_IFMT    = 6'h0b;
    localparam logic [5:0] IDX_EVT     = 6'h0c;
    localparam logic [5:0] IDX_BKD     = 6'h0d;
    // interrupt_format_control fields
    localparam int B_HOLD = 7;
    localparam int B_PIE  = 6;
    localparam int B_AIE  = 5;
    localparam int B_UIE  = 4;
    localparam int B_NUM  = 2;
    localparam int B_HOUR = 1;
    localparam int B_DSE  = 0;
    // event_status fields
    localparam int C_IRQ  = 7;
    localparam int C_PER  = 6;
    localparam int C_ALM  = 5;
    localparam int C_UPD  = 4;
    localparam logic [2:0] CHAIN_RUN  = 3'h2;
    localparam logic [2:0] CHAIN_RUN2 = 3'h3;
    localparam logic [1:0] CHAIN_HELD = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] DST_APR    = 8'h04;
    localparam logic [7:0] DST_OCT    = 8'h10;
    localparam logic [7:0] DST_SUN    = 8'h01;
    localparam logic [7:0] DST_HOUR   = 8'h01;
    localparam logic [7:0] DST_59     = 8'h59;
    localparam logic [7:0] DST_DOM7   = 8'h07;
    localparam logic [7:0] DST_DOM25  = 8'h25;
endpackage
`default_nettype wire

// File: rtcaic_top.sv
// rtcaic_top: alarm, periodic and update events, clock chain control,
// format and daylight-saving decode, reached over Avalon-MM.
// assumes the calendar counter sits outside on the same clock, takes
// update_strobe and the dst pulses, and presents the time bytes.
`timescale 1ns/1ps
`default_nettype none
module rtcaic_top
    import rtcaic_pkg::*;
#(
    parameter int TICK_DIV_P = rtcaic_pkg::TICK_DIV,
    parameter int CSR_CYC_P  = rtcaic_pkg::CSR_CYCLES,
    parameter int BUC_P      = rtcaic_pkg::BUC_TICKS
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [7:0]  sec_in,
    input  wire logic [7:0]  min_in,
    input  wire logic [7:0]  hour_in,
    input  wire logic [7:0]  dom_in,
    input  wire logic [7:0]  dow_in,
    input  wire logic [7:0]  mon_in,
    input  wire logic        power_fail,
    input  wire logic        backup_valid,
    output logic             update_strobe,
    output logic             dst_forward,
    output logic             dst_back,
    output logic             copy_enable,
    output logic             hour_format,
    output logic             number_format,
    output logic             osc_on,
    output logic             write_protect,
    output logic             irq_o,
    output logic             irq_oe
);
    import rtcaic_pkg::*;

    function automatic logic [7:0] fmt(input logic [7:0] v,
                                       input logic bin);
        // bcd literal turned into binary when binary format is chosen
        fmt = bin ? 8'((v[7:4] * 10) + v[3:0]) : v;
    endfunction

    function automatic logic [14:0] rate_mask(input logic [3:0] rs);
        logic [3:0] k;
        k = (rs == 4'h1) ? 4'h7 : (rs == 4'h2) ? 4'h8 : 4'(rs - 4'h1);
        rate_mask = 15'((32'h1 << k) - 32'h1);
    endfunction

    function automatic logic dc(input logic [7:0] a);
        dc = (a[7:6] == 2'h3);
    endfunction

    logic        ack_reg;
    logic [31:0] rdata_reg;
    logic [3:0]  rate_reg;
    logic [2:0]  chain_reg;
    logic        hold_reg, pie_reg, aie_reg, uie_reg;
    logic        num_reg, hour_reg, dse_reg;
    logic [5:0]  adom_reg;
    logic [7:0]  asec_reg, amin_reg, ahr_reg;
    logic        pf_reg, af_reg, uf_reg, irq_pending_flag_reg;
    logic        pf_next, af_next, uf_next, irq_pending_flag_next;
    logic [2:0]  pfl_s, bkv_s;
    logic        pfail_reg, bkv_reg;
    logic [31:0] wp_cnt;
    logic [15:0] div_cnt;
    logic [14:0] sub_cnt;
    logic        pend_reg, upd_d, fall_done;
    logic        run, tick, upd_evt, per_evt, alarm_hit;
    logic        spring, fall;
    logic [5:0]  idx;
    logic        rd_go, wr_go, clr_c, prot;

    // bus slave: one wait cycle, then the answer
    assign idx   = avs_address[7:2];
    assign rd_go = avs_read & ~ack_reg;
    assign wr_go = avs_write & ack_reg;
    assign clr_c = rd_go & (idx == IDX_EVT);
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 32'h0;
        end else if (rd_go) begin
            unique case (idx)
                IDX_SEC_ALM: rdata_reg <= {24'h0, asec_reg};
                IDX_MIN_ALM: rdata_reg <= {24'h0, amin_reg};
                IDX_HR_ALM:  rdata_reg <= {24'h0, ahr_reg};
                IDX_RATE:    rdata_reg <= {24'h0, pend_reg, chain_reg,
                                           rate_reg};
                IDX_IFMT:    rdata_reg <= {24'h0, hold_reg, pie_reg,
                                           aie_reg, uie_reg, 1'b0,
                                           num_reg, hour_reg, dse_reg};
                IDX_EVT:     rdata_reg <= {24'h0, irq_pending_flag_reg, pf_reg,
                                           af_reg, uf_reg, 4'h0};
                IDX_BKD:     rdata_reg <= {24'h0, bkv_reg, 1'b0,
                                           adom_reg};
                default:     rdata_reg <= 32'h0;
            endcase
        end
    end

    // control registers; status bits ignore writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rate_reg  <= 4'h0;
            chain_reg <= 3'h0;
            hold_reg  <= 1'b0;
            pie_reg   <= 1'b0;
            aie_reg   <= 1'b0;
            uie_reg   <= 1'b0;
            num_reg   <= 1'b0;
            hour_reg  <= 1'b0;
            dse_reg   <= 1'b0;
            adom_reg  <= 6'h0;
        end else if (wr_go) begin
            if (idx == IDX_RATE) begin
                rate_reg  <= avs_writedata[3:0];
                chain_reg <= avs_writedata[6:4];
            end
            if (idx == IDX_IFMT) begin
                hold_reg <= avs_writedata[B_HOLD];
                pie_reg  <= avs_writedata[B_PIE];
                aie_reg  <= avs_writedata[B_AIE];
                uie_reg  <= avs_writedata[B_UIE] &
                            ~avs_writedata[B_HOLD];
                num_reg  <= avs_writedata[B_NUM];
                hour_reg <= avs_writedata[B_HOUR];
                dse_reg  <= avs_writedata[B_DSE];
            end
            if (idx == IDX_BKD) begin
                adom_reg <= avs_writedata[5:0];
            end
        end
    end

    // alarm bytes are clock storage: blocked while protected
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            asec_reg <= RESET_BYTE;
            amin_reg <= RESET_BYTE;
            ahr_reg  <= RESET_BYTE;
        end else if (wr_go && !prot) begin
            if (idx == IDX_SEC_ALM) begin
                asec_reg <= avs_writedata[7:0];
            end
            if (idx == IDX_MIN_ALM) begin
                amin_reg <= avs_writedata[7:0];
            end
            if (idx == IDX_HR_ALM) begin
                ahr_reg <= avs_writedata[7:0];
            end
        end
    end

    // pin inputs: three stages, accepted once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pfl_s     <= 3'h0;
            bkv_s     <= 3'h0;
            pfail_reg <= 1'b0;
            bkv_reg   <= 1'b0;
        end else begin
            pfl_s <= {pfl_s[1:0], power_fail};
            bkv_s <= {bkv_s[1:0], backup_valid};
            if (pfl_s[1] == pfl_s[2]) begin
                pfail_reg <= pfl_s[2];
            end
            if (bkv_s[1] == bkv_s[2]) begin
                bkv_reg <= bkv_s[2];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_cnt <= 32'h0;
        end else if (pfail_reg) begin
            wp_cnt <= 32'(CSR_CYC_P);
        end else if (wp_cnt != 32'h0) begin
            wp_cnt <= wp_cnt - 32'h1;
        end
    end
    assign prot          = pfail_reg | (wp_cnt != 32'h0);
    assign write_protect = prot;

    // clock chain: 010 and 011 run, 11x holds the divider
    assign run    = (chain_reg == CHAIN_RUN) | (chain_reg == CHAIN_RUN2);
    assign osc_on = run | (chain_reg[2:1] == CHAIN_HELD);
    assign tick   = run && (div_cnt == 16'(TICK_DIV_P - 1));

    // timekeeping runs regardless of power fail
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= 16'h0;
            sub_cnt <= 15'(HALF_TICKS);
        end else if (!run) begin
            div_cnt <= 16'h0;
            // held at half a second so the first update comes 500ms on
            sub_cnt <= 15'(HALF_TICKS);
        end else begin
            div_cnt <= tick ? 16'h0 : 16'(div_cnt + 16'h1);
            if (tick) begin
                sub_cnt <= 15'(sub_cnt + 15'h1);
            end
        end
    end

    assign upd_evt = tick && (sub_cnt == 15'(SEC_TICKS - 1));
    assign per_evt = tick && (rate_reg != 4'h0) &&
                     ((sub_cnt & rate_mask(rate_reg)) ==
                      rate_mask(rate_reg));

    // pending covers the lead window and drops as update_strobe rises
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= run && !hold_reg && !upd_evt &&
                        (sub_cnt >= 15'(SEC_TICKS - BUC_P));
        end
    end

    // daylight saving decode on the old time, 1:59:59 about to roll
    assign spring = dse_reg && (mon_in == fmt(DST_APR, num_reg)) &&
                    (dow_in == DST_SUN) &&
                    (dom_in <= fmt(DST_DOM7, num_reg)) &&
                    (hour_in == DST_HOUR) &&
                    (min_in == fmt(DST_59, num_reg)) &&
                    (sec_in == fmt(DST_59, num_reg));
    assign fall   = dse_reg && (mon_in == fmt(DST_OCT, num_reg)) &&
                    (dow_in == DST_SUN) &&
                    (dom_in >= fmt(DST_DOM25, num_reg)) &&
                    (hour_in == DST_HOUR) &&
                    (min_in == fmt(DST_59, num_reg)) &&
                    (sec_in == fmt(DST_59, num_reg));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            update_strobe <= 1'b0;
            dst_forward   <= 1'b0;
            dst_back      <= 1'b0;
            fall_done     <= 1'b0;
            upd_d         <= 1'b0;
        end else begin
            update_strobe <= upd_evt;
            upd_d         <= update_strobe;
            dst_forward   <= upd_evt && spring;
            // fall back only on the first pass through 1:59:59
            dst_back      <= upd_evt && fall && !fall_done;
            if (upd_evt && fall) begin
                fall_done <= 1'b1;
            end else if (dow_in != DST_SUN) begin
                fall_done <= 1'b0;
            end
        end
    end

    assign copy_enable   = ~hold_reg;
    assign hour_format   = hour_reg;
    assign number_format = num_reg;

    // compared one cycle after the strobe, on the new time bytes
    assign alarm_hit = upd_d &&
        (dc(asec_reg) || asec_reg == sec_in) &&
        (dc(amin_reg) || amin_reg == min_in) &&
        (dc(ahr_reg)  || ahr_reg == hour_in) &&
        (adom_reg == 6'h0 || {2'h0, adom_reg} == dom_in);

    // flags: an event in the clearing cycle wins over the read
    always_comb begin
        pf_next   = per_evt | (pf_reg & ~clr_c);
        af_next   = alarm_hit | (af_reg & ~clr_c);
        uf_next   = update_strobe | (uf_reg & ~clr_c);
        irq_pending_flag_next = (pie_reg & pf_next) |
                    (aie_reg & af_next) |
                    (uie_reg & ~hold_reg & uf_next) |
                    (irq_pending_flag_reg & ~clr_c);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pf_reg   <= 1'b0;
            af_reg   <= 1'b0;
            uf_reg   <= 1'b0;
            irq_pending_flag_reg <= 1'b0;
        end else begin
            pf_reg   <= pf_next;
            af_reg   <= af_next;
            uf_reg   <= uf_next;
            irq_pending_flag_reg <= irq_pending_flag_next;
        end
    end

    // open-drain request: pulled low while the summary flag is set
    assign irq_o  = 1'b0;
    assign irq_oe = irq_pending_flag_reg;

    logic [15:0] gap_cnt;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_cnt <= 16'hffff;
        end else if (!run) begin
            gap_cnt <= 16'hffff;
        end else if (upd_evt) begin
            gap_cnt <= 16'h0;
        end else if (tick && gap_cnt != 16'hffff) begin
            gap_cnt <= 16'(gap_cnt + 16'h1);
        end
    end

    a_upd_gap: assert property (@(posedge clk) disable iff (!rstn)
        upd_evt |-> gap_cnt >= 16'(GAP_MIN_TICKS - 1))
        else $error("updates too close together");
    a_summary_set: assert property (@(posedge clk) disable iff (!rstn)
        (pf_reg && pie_reg && !clr_c) |=> irq_pending_flag_reg)
        else $error("summary flag missing");
    a_read_clear: assert property (@(posedge clk) disable iff (!rstn)
        (clr_c && !per_evt && !alarm_hit && !update_strobe) |=>
        (!pf_reg && !af_reg && !uf_reg && !irq_oe))
        else $error("status read did not clear");
    a_alarm_flag: assert property (@(posedge clk) disable iff (!rstn)
        alarm_hit |=> af_reg && (irq_pending_flag_reg || !$past(aie_reg)))
        else $error("alarm flag not set");
    a_all_dc: assert property (@(posedge clk) disable iff (!rstn)
        (upd_d && dc(asec_reg) && dc(amin_reg) && dc(ahr_reg) &&
         adom_reg == 6'h0) |-> alarm_hit)
        else $error("don't care alarm missed");
    a_dom_miss: assert property (@(posedge clk) disable iff (!rstn)
        (adom_reg != 6'h0 && {2'h0, adom_reg} != dom_in) |->
        !alarm_hit)
        else $error("alarm fired on wrong day");
    a_hold_uie: assert property (@(posedge clk) disable iff (!rstn)
        hold_reg |-> !uie_reg)
        else $error("update enable kept under hold");
    a_hold_pend: assert property (@(posedge clk) disable iff (!rstn)
        hold_reg ##1 hold_reg |-> !pend_reg)
        else $error("pending set under hold");
    a_pend_lead: assert property (@(posedge clk) disable iff (!rstn)
        ($rose(update_strobe) && !hold_reg && $past(hold_reg) == 1'b0
         && $past(pend_reg)) |=> !pend_reg)
        else $error("pending not cleared at update end");
    a_chain_run: assert property (@(posedge clk) disable iff (!rstn)
        (chain_reg == CHAIN_RUN2) |-> (osc_on && run))
        else $error("code 011 not running");
    a_upd_irq: assert property (@(posedge clk) disable iff (!rstn)
        (update_strobe && uie_reg && !hold_reg) |=> irq_pending_flag_reg)
        else $error("update request missing");
    a_wp_block: assert property (@(posedge clk) disable iff (!rstn)
        (wr_go && prot && idx == IDX_SEC_ALM) |=> $stable(asec_reg))
        else $error("write passed protection");

    c_update: cover property (@(posedge clk) disable iff (!rstn)
        update_strobe);
    c_alarm: cover property (@(posedge clk) disable iff (!rstn)
        alarm_hit && aie_reg);
    c_clear_irq: cover property (@(posedge clk) disable iff (!rstn)
        clr_c && irq_pending_flag_reg);
    c_dst: cover property (@(posedge clk) disable iff (!rstn)
        dst_forward || dst_back);
endmodule
`default_nettype wire

// File: rtcaic_cal_model.sv
// rtcaic_cal_model: calendar counter standing beyond the update link
// assumes update_strobe pulses once for each second of time
`timescale 1ns/1ps
`default_nettype none
module rtcaic_cal_model (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       update_strobe,
    input  wire logic       dst_forward,
    input  wire logic       dst_back,
    output logic      [7:0] sec,
    output logic      [7:0] hour
);
    // bcd seconds only; a short run never reaches the minute wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sec  <= 8'h00;
            hour <= 8'h01;
        end else if (update_strobe) begin
            sec <= (sec[3:0] == 4'h9) ? {sec[7:4] + 4'h1, 4'h0} : sec + 8'h01;
            if (dst_forward) hour <= 8'h03;
            if (dst_back) hour <= 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: rtc_alarm_irq_control_bench.sv
// rtc_alarm_irq_control_bench: self-checking bench of rtcaic_top
// assumes a one-cycle tick divider so that two updates fit the run
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_irq_control_bench;
    import rtcaic_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        power_fail = 1'b0;
    logic        backup_valid = 1'b1;
    logic [7:0]  mn = 8'h00, dom = 8'h01, dow = 8'h02, mon = 8'h01;
    logic        update_strobe, dst_forward, dst_back, copy_enable;
    logic        hour_format, number_format, osc_on, write_protect, irq_oe;
    logic [7:0]  sec, hour, rv, d, c;
    logic        irq_seen;
    int          n_fail = 0;
    int          checked = 0;
    int          cyc = 0;
    int          seed = 70;
    int          t0, ts1, ts2, tp, i;

    always #2 clk = ~clk;

    rtcaic_top #(.TICK_DIV_P(1), .CSR_CYC_P(10), .BUC_P(BUC_TICKS)) DUT (
        .clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sec_in(sec), .min_in(mn),
        .hour_in(hour), .dom_in(dom), .dow_in(dow), .mon_in(mon),
        .power_fail(power_fail), .backup_valid(backup_valid),
        .update_strobe(update_strobe), .dst_forward(dst_forward),
        .dst_back(dst_back), .copy_enable(copy_enable),
        .hour_format(hour_format), .number_format(number_format),
        .osc_on(osc_on), .write_protect(write_protect), .irq_o(),
        .irq_oe(irq_oe));

    rtcaic_cal_model cal (
        .clk(clk), .rstn(rstn), .update_strobe(update_strobe),
        .dst_forward(dst_forward), .dst_back(dst_back),
        .sec(sec), .hour(hour));

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task summarize;
        if (n_fail == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    // accesses target registers or the unmapped 8'h3c: no extended space select
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] wd);
        @(posedge clk);
        avs_address   <= a;
        avs_read      <= ~w;
        avs_write     <= w;
        avs_writedata <= {24'h0, wd};
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rv = avs_readdata[7:0];
        irq_seen = irq_oe;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        bus(1'b1, a, wd);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 8'h00);
    endtask

    // returns at the first falling edge that sees update_strobe high, while the update is on
    task automatic wait_upd(output int t);
        @(negedge clk);
        while (update_strobe !== 1'b1) @(negedge clk);
        t = cyc;
    endtask

    // the whole sequence needs about 50k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            summarize;
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h28); chk("rate_ctrl", rv, 8'h00);
        rd(8'h2c); chk("irq_fmt", rv, 8'h00);
        rd(8'h30); chk("evt", rv, 8'h00);
        rd(8'h34); chk("bkd", rv, 8'h80);
        rd(8'h3c); chk("unmapped", rv, 8'h00);
        wr(8'h04, 8'h01);
        wr(8'h0c, 8'hc0);
        wr(8'h14, 8'hc0);
        wr(8'h34, 8'h01);
        wr(8'h28, 8'h23);
        t0 = cyc;
        wr(8'h2c, 8'h40);
        for (i = 0; i < 50 && irq_oe !== 1'b1; i++) @(negedge clk);
        chk("irq_per", irq_oe, 1'b1);
        rd(8'h30); chk("evt_per", rv & 8'hc0, 8'hc0);
        wr(8'h2c, 8'h20);
        // periodic now masked, so only the alarm can set the summary again
        rd(8'h30);
        chk("irq_release", irq_seen, 1'b0);
        repeat (20) @(negedge clk);
        chk("irq_masked", irq_oe, 1'b0);
        rd(8'h30); chk("evt_masked", rv & 8'hc0, 8'h40);
        wait_upd(ts1);
        chk("first_upd", ts1 - t0 >= HALF_TICKS - 8 &&
            ts1 - t0 <= HALF_TICKS + 8, 1'b1);
        repeat (4) @(negedge clk);
        chk("irq_alarm", irq_oe, 1'b1);
        rd(8'h30); chk("evt_alarm", rv & 8'hb0, 8'hb0);
        rd(8'h28); chk("pending_end", rv[7], 1'b0);
        // seconds match at the next update but the day does not
        wr(8'h04, 8'h02);
        dom <= 8'h02;
        wr(8'h2c, 8'h30);
        do rd(8'h28); while (rv[7] !== 1'b1);
        tp = cyc;
        wait_upd(ts2);
        chk("lead", ts2 - tp >= 1 && ts2 - tp <= BUC_TICKS + 4, 1'b1);
        chk("gap", ts2 - ts1 == SEC_TICKS, 1'b1);
        repeat (4) @(negedge clk);
        rd(8'h30); chk("evt_upd", rv & 8'hb0, 8'h90);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            d[3] = 1'b0;
            wr(8'h2c, d);
            rd(8'h2c); chk("irq_fmt", rv, d[7] ? d & 8'hef : d);
            chk("hour_fmt", hour_format, d[1]);
            chk("num_fmt", number_format, d[2]);
            chk("copy", copy_enable, !d[7]);
        end
        wr(8'h2c, 8'h90);
        rd(8'h2c); chk("hold_uie", rv, 8'h80);
        chk("copy_hold", copy_enable, 1'b0);
        for (i = 0; i < 8; i++) begin
            c = i;
            wr(8'h28, {1'b1, c[2:0], 4'h0});
            rd(8'h28); chk("rate_ctrl", rv, {1'b0, c[2:0], 4'h0});
            chk("osc_on", osc_on, c[1]);
        end
        wr(8'h34, 8'hff);
        rd(8'h34); chk("bkd", rv, 8'hbf);
        rd(8'h30);
        wr(8'h30, 8'hff);
        rd(8'h30); chk("evt_ro", rv, 8'h00);
        wr(8'h3c, 8'haa);
        rd(8'h3c); chk("unmapped", rv, 8'h00);
        power_fail <= 1'b1;
        repeat (6) @(posedge clk);
        chk("wp_on", write_protect, 1'b1);
        wr(8'h04, 8'h22);
        rd(8'h04); chk("sec_alarm_wp", rv, 8'h02);
        power_fail <= 1'b0;
        repeat (6) @(negedge clk);
        chk("wp_hold", write_protect, 1'b1);
        repeat (30) @(negedge clk);
        chk("wp_off", write_protect, 1'b0);
        wr(8'h04, 8'h22);
        rd(8'h04); chk("sec_alarm", rv, 8'h22);
        summarize;
    end
endmodule
`default_nettype wire
